/* File: tmc_pkg.sv */
// tmc_pkg: constants for the 8-bit timer/counter with compare
// assumes one 40 MHz clock; registers are plain ports, no bus
//
// Contract
// - writing one to shared prescaler reset resets the shared prescaler
// - prescaler reset self-clears next cycle unless sync mode holds it
// - prescaler reset restarts tick phase of all three timers
// - counter and compare values are eight bits wide
// - each event shows as a flag and is individually maskable
// - tick source zero stops counting; counter stays writable
// - three-bit tick source select chooses prescaled or external tick
// - 0x00 is bottom, 0xFF is max, both signalled to waveform logic
// - top is 0xFF or compare value depending on waveform mode
// - each tick clears, increments or decrements the counter
// - software counter write beats clear and count
// - two-bit waveform mode sets the counting sequence
// - overflow flag set at mode-defined point, may request interrupt
// - eight-bit comparator signals match whenever counter equals compare
// - match sets compare flag on the following tick
// - compare irq only when flag, enable and global enable are set
// - compare flag clears on service or writing one
// - compare output derived from match, modes, max and bottom; code never reads bottom, phase pwm uses count direction instead
// - pwm modes write a buffer, active compare updated from it
// - normal and ctc modes write the active compare directly
// - clearing sync mode clears held prescaler reset bits
// - select 7 counts rising, 6 counts falling external edges
package tmc_pkg;

   // ----------------------------------------------------------------
   // widths and extremes
   // ----------------------------------------------------------------
   localparam int        CNT_W      = 8;
   localparam logic [7:0] CNT_BOTTOM = 8'h00;
   localparam logic [7:0] CNT_MAX    = 8'hFF;
   localparam logic [7:0] CNT_RESET  = 8'h00;

   // ----------------------------------------------------------------
   // prescaler taps and counter width
   // ----------------------------------------------------------------
   localparam int PRE_W    = 10;
   localparam int TAP_DIV8 = 3;
   localparam int TAP_D64  = 6;
   localparam int TAP_D256 = 8;
   localparam int TAP_D1K  = 10;

   // ----------------------------------------------------------------
   // tick source select encodings
   // ----------------------------------------------------------------
   localparam logic [2:0] SRC_STOP  = 3'h0;
   localparam logic [2:0] SRC_CLK   = 3'h1;
   localparam logic [2:0] SRC_DIV8  = 3'h2;
   localparam logic [2:0] SRC_D64   = 3'h3;
   localparam logic [2:0] SRC_D256  = 3'h4;
   localparam logic [2:0] SRC_D1K   = 3'h5;
   localparam logic [2:0] SRC_EXTFL = 3'h6;
   localparam logic [2:0] SRC_EXTRS = 3'h7;

   // ----------------------------------------------------------------
   // waveform modes
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      WGM_NORMAL = 2'h0,
      WGM_PHPWM  = 2'h1,
      WGM_CTC    = 2'h2,
      WGM_FASTPWM = 2'h3
   } tmc_wave_e;

   // compare output modes
   localparam logic [1:0] COM_OFF    = 2'h0;
   localparam logic [1:0] COM_TOGGLE = 2'h1;
   localparam logic [1:0] COM_CLEAR  = 2'h2;
   localparam logic [1:0] COM_SET    = 2'h3;

   // reset values of control state
   localparam logic       OUT_RESET = 1'b0;

endpackage

/* File: tmc_prescaler.sv */
// tmc_prescaler: free-running 10-bit prescaler shared by three timers
// assumes reset request is a level held by the owner for as long as wanted
`timescale 1ns/1ps
module tmc_prescaler #(
   parameter int PW = tmc_pkg::PRE_W
) (
   // clock and reset
   input  wire logic          sys_clk,
   input  wire logic          rst_b,
   // control
   input  wire logic          preReset,
   // taps, one-cycle enables
   output logic               tapDiv8,
   output logic               tapDiv64,
   output logic               tapDiv256,
   output logic               tapDiv1k
);

   // refused at elaboration: the slowest tap needs every counter bit
   if (PW < tmc_pkg::TAP_D1K) begin : g_width_chk
      $error("prescaler too narrow");
   end

   logic [PW-1:0] preCnt_ff;

   // ----------------------------------------------------------------
   // counter; reset restarts every tap phase at once
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         preCnt_ff <= '0;
      end else if (preReset) begin
         preCnt_ff <= '0;
      end else begin
         preCnt_ff <= preCnt_ff + PW'(1);
      end
   end

   function automatic logic tapHit(input logic [PW-1:0] c, input int bits);
      logic [PW-1:0] m;
      m = PW'((1 << bits) - 1);
      return (c & m) == m;
   endfunction

   // taps fire on the last cycle of each period; held off during reset
   assign tapDiv8   = !preReset && tapHit(preCnt_ff, tmc_pkg::TAP_DIV8);
   assign tapDiv64  = !preReset && tapHit(preCnt_ff, tmc_pkg::TAP_D64);
   assign tapDiv256 = !preReset && tapHit(preCnt_ff, tmc_pkg::TAP_D256);
   assign tapDiv1k  = !preReset && tapHit(preCnt_ff, tmc_pkg::TAP_D1K);

   chk_reset_phase: assert property (@(posedge sys_clk) disable iff (!rst_b)
      preReset |=> preCnt_ff == '0) else $error("prescaler not restarted");

endmodule

/* File: tmc_ext_edge.sv */
// tmc_ext_edge: samples the external count pin and makes edge pulses
// assumes the pin is synchronous to sys_clk
`timescale 1ns/1ps
module tmc_ext_edge (
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic rst_b,
   // pin
   input  wire logic externalCountPin,
   // edges, one-cycle pulses
   output logic      riseTick,
   output logic      fallTick
);

   logic sampA_ff;
   logic sampB_ff;

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         sampA_ff <= 1'b0;
         sampB_ff <= 1'b0;
      end else begin
         sampA_ff <= externalCountPin;
         sampB_ff <= sampA_ff;
      end
   end

   assign riseTick = sampA_ff && !sampB_ff;
   assign fallTick = !sampA_ff && sampB_ff;

   chk_rise_edge: assert property (@(posedge sys_clk) disable iff (!rst_b)
      riseTick |=> !riseTick) else $error("rise pulse too long");

endmodule

/* File: tmc_timer.sv */
// tmc_timer: 8-bit timer/counter with compare, flags and prescaler reset
// assumes software bits are plain synchronous ports; one write per cycle
`timescale 1ns/1ps
module tmc_timer #(
   parameter int CW = tmc_pkg::CNT_W
) (
   // clock and reset
   input  wire logic          sys_clk,
   input  wire logic          rst_b,
   // timer control
   input  wire logic [2:0]    tickSourceSelect,
   input  wire logic [1:0]    waveformMode,
   input  wire logic [1:0]    compareOutputMode,
   // prescaler reset control
   input  wire logic          timerSyncModeWr,
   input  wire logic          timerSyncModeIn,
   input  wire logic          prescalerResetWr,
   input  wire logic          prescalerResetIn,
   output logic               timerSyncMode,
   output logic               sharedPrescalerReset,
   // counter value access
   input  wire logic          counterWr,
   input  wire logic [CW-1:0] counterWrData,
   output logic [CW-1:0]      counterValue,
   // compare value access
   input  wire logic          compareWr,
   input  wire logic [CW-1:0] compareWrData,
   output logic [CW-1:0]      compareValue,
   // flags and masks
   input  wire logic          flagClrMatch,
   input  wire logic          flagClrOvf,
   input  wire logic          matchVectorTaken,
   input  wire logic          ovfVectorTaken,
   input  wire logic          compareIrqEnable,
   input  wire logic          overflowIrqEnable,
   input  wire logic          globalIrqEnable,
   output logic               compareMatchFlag,
   output logic               overflowFlag,
   output logic               compareIrq,
   output logic               overflowIrq,
   // external pin and waveform
   input  wire logic          externalCountPin,
   output logic               compareOutput,
   output logic               atBottom,
   output logic               atMax,
   output logic               timerTick
);

   if (CW != tmc_pkg::CNT_W) begin : g_width_chk
      $error("counter width must be eight");
   end

   // ----------------------------------------------------------------
   // shared prescaler reset and sync mode
   // ----------------------------------------------------------------
   logic syncMode_ff;
   logic preRst_ff;
   logic nxt_preRst;

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         syncMode_ff <= 1'b0;
      end else if (timerSyncModeWr) begin
         syncMode_ff <= timerSyncModeIn;
      end
   end

   always_comb begin
      nxt_preRst = preRst_ff;
      if (!syncMode_ff) begin
         nxt_preRst = 1'b0;
      end
      if (timerSyncModeWr && !timerSyncModeIn) begin
         nxt_preRst = 1'b0;
      end
      if (prescalerResetWr && prescalerResetIn) begin
         nxt_preRst = 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         preRst_ff <= 1'b0;
      end else begin
         preRst_ff <= nxt_preRst;
      end
   end

   assign timerSyncMode        = syncMode_ff;
   assign sharedPrescalerReset = preRst_ff;

   logic tapDiv8;
   logic tapDiv64;
   logic tapDiv256;
   logic tapDiv1k;

   tmc_prescaler #(.PW(tmc_pkg::PRE_W)) u_pre (
      .sys_clk   (sys_clk),
      .rst_b     (rst_b),
      .preReset  (preRst_ff),
      .tapDiv8   (tapDiv8),
      .tapDiv64  (tapDiv64),
      .tapDiv256 (tapDiv256),
      .tapDiv1k  (tapDiv1k)
   );

   logic riseTick;
   logic fallTick;

   tmc_ext_edge u_ext (
      .sys_clk          (sys_clk),
      .rst_b            (rst_b),
      .externalCountPin (externalCountPin),
      .riseTick         (riseTick),
      .fallTick         (fallTick)
   );

   // ----------------------------------------------------------------
   // tick source select
   // ----------------------------------------------------------------
   logic tick;

   always_comb begin
      case (tickSourceSelect)
         tmc_pkg::SRC_STOP:  tick = 1'b0;
         tmc_pkg::SRC_CLK:   tick = 1'b1;
         tmc_pkg::SRC_DIV8:  tick = tapDiv8;
         tmc_pkg::SRC_D64:   tick = tapDiv64;
         tmc_pkg::SRC_D256:  tick = tapDiv256;
         tmc_pkg::SRC_D1K:   tick = tapDiv1k;
         tmc_pkg::SRC_EXTFL: tick = fallTick;
         tmc_pkg::SRC_EXTRS: tick = riseTick;
         default:            tick = 1'b0;
      endcase
   end

   assign timerTick = tick;

   // ----------------------------------------------------------------
   // mode decode, compare buffer, top
   // ----------------------------------------------------------------
   tmc_pkg::tmc_wave_e mode;
   assign mode = tmc_pkg::tmc_wave_e'(waveformMode);

   function automatic logic isPwm(input tmc_pkg::tmc_wave_e m);
      return m == tmc_pkg::WGM_PHPWM || m == tmc_pkg::WGM_FASTPWM;
   endfunction

   logic [CW-1:0] cnt_ff;
   logic [CW-1:0] cmpAct_ff;
   logic [CW-1:0] cmpBuf_ff;
   logic          dirDown_ff;
   logic [CW-1:0] top;

   assign top      = (mode == tmc_pkg::WGM_CTC) ? cmpAct_ff : tmc_pkg::CNT_MAX;
   assign atBottom = cnt_ff == tmc_pkg::CNT_BOTTOM;
   assign atMax    = cnt_ff == tmc_pkg::CNT_MAX;

   // phase pwm and fast pwm both load on the tick at max of the sequence
   logic bufLoad;
   assign bufLoad = tick && ((mode == tmc_pkg::WGM_PHPWM && atMax) ||
                             (mode == tmc_pkg::WGM_FASTPWM && atMax));

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         cmpBuf_ff <= tmc_pkg::CNT_RESET;
      end else if (compareWr) begin
         cmpBuf_ff <= compareWrData;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         cmpAct_ff <= tmc_pkg::CNT_RESET;
      end else if (compareWr && !isPwm(mode)) begin
         cmpAct_ff <= compareWrData;
      end else if (isPwm(mode) && bufLoad) begin
         cmpAct_ff <= cmpBuf_ff;
      end
   end

   assign compareValue = isPwm(mode) ? cmpBuf_ff : cmpAct_ff;

   // ----------------------------------------------------------------
   // counter
   // ----------------------------------------------------------------
   logic [CW-1:0] nxt_cnt;
   logic          nxt_dirDown;
   logic          ovfEvt;

   always_comb begin
      nxt_cnt     = cnt_ff;
      nxt_dirDown = dirDown_ff;
      ovfEvt      = 1'b0;
      if (tick) begin
         case (mode)
            tmc_pkg::WGM_PHPWM: begin
               if (dirDown_ff) begin
                  nxt_cnt = cnt_ff - CW'(1);
                  if (cnt_ff == tmc_pkg::CNT_BOTTOM + CW'(1)) nxt_dirDown = 1'b0;
               end else begin
                  nxt_cnt = cnt_ff + CW'(1);
                  if (cnt_ff == tmc_pkg::CNT_MAX - CW'(1)) nxt_dirDown = 1'b1;
               end
               ovfEvt = atBottom;
            end
            tmc_pkg::WGM_CTC: begin
               nxt_cnt = (cnt_ff == top) ? tmc_pkg::CNT_BOTTOM : cnt_ff + CW'(1);
               ovfEvt  = atMax;
            end
            default: begin
               nxt_cnt = cnt_ff + CW'(1);
               ovfEvt  = atMax;
            end
         endcase
      end
      if (counterWr) begin
         nxt_cnt = counterWrData;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_ff <= tmc_pkg::CNT_RESET;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         dirDown_ff <= 1'b0;
      end else if (mode != tmc_pkg::WGM_PHPWM) begin
         dirDown_ff <= 1'b0;
      end else begin
         dirDown_ff <= nxt_dirDown;
      end
   end

   assign counterValue = cnt_ff;

   // ----------------------------------------------------------------
   // comparator; a counter write blocks the match on the next tick
   // ----------------------------------------------------------------
   logic match;
   logic blockMatch_ff;
   logic matchPend_ff;

   assign match = cnt_ff == cmpAct_ff;

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         blockMatch_ff <= 1'b0;
      end else if (counterWr) begin
         blockMatch_ff <= 1'b1;
      end else if (tick) begin
         blockMatch_ff <= 1'b0;
      end
   end

   // flag rises on the tick following the match
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         matchPend_ff <= 1'b0;
      end else if (tick) begin
         matchPend_ff <= 1'b0;
      end else if (match && !blockMatch_ff && !counterWr) begin
         matchPend_ff <= 1'b1;
      end
   end

   logic matchEvt;
   // a counter write also cancels a match left pending from before it
   assign matchEvt = tick && !blockMatch_ff && (matchPend_ff || match);

   // ----------------------------------------------------------------
   // flags: set wins over clear
   // ----------------------------------------------------------------
   logic cmpFlag_ff;
   logic ovfFlag_ff;

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         cmpFlag_ff <= 1'b0;
      end else if (matchEvt) begin
         cmpFlag_ff <= 1'b1;
      end else if (flagClrMatch || matchVectorTaken) begin
         cmpFlag_ff <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         ovfFlag_ff <= 1'b0;
      end else if (ovfEvt) begin
         ovfFlag_ff <= 1'b1;
      end else if (flagClrOvf || ovfVectorTaken) begin
         ovfFlag_ff <= 1'b0;
      end
   end

   assign compareMatchFlag = cmpFlag_ff;
   assign overflowFlag     = ovfFlag_ff;
   assign compareIrq  = cmpFlag_ff && compareIrqEnable && globalIrqEnable;
   assign overflowIrq = ovfFlag_ff && overflowIrqEnable && globalIrqEnable;

   // ----------------------------------------------------------------
   // waveform output
   // ----------------------------------------------------------------
   logic oc_ff;
   logic nxt_oc;

   always_comb begin
      nxt_oc = oc_ff;
      case (compareOutputMode)
         tmc_pkg::COM_TOGGLE: if (matchEvt && !isPwm(mode)) nxt_oc = !oc_ff;
         tmc_pkg::COM_CLEAR: begin
            if (matchEvt) nxt_oc = (mode == tmc_pkg::WGM_PHPWM) ? dirDown_ff : 1'b0;
            else if (tick && mode == tmc_pkg::WGM_FASTPWM && atMax) nxt_oc = 1'b1;
         end
         tmc_pkg::COM_SET: begin
            if (matchEvt) nxt_oc = (mode == tmc_pkg::WGM_PHPWM) ? !dirDown_ff : 1'b1;
            else if (tick && mode == tmc_pkg::WGM_FASTPWM && atMax) nxt_oc = 1'b0;
         end
         default: nxt_oc = oc_ff;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         oc_ff <= tmc_pkg::OUT_RESET;
      end else begin
         oc_ff <= nxt_oc;
      end
   end

   assign compareOutput = oc_ff;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   chk_presc_selfclr: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (prescalerResetWr && prescalerResetIn && !syncMode_ff && !timerSyncModeWr)
      |=> preRst_ff ##1 !preRst_ff) else $error("prescaler reset did not self clear");
   chk_presc_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (preRst_ff && syncMode_ff && !timerSyncModeWr) |=> preRst_ff)
      else $error("held prescaler reset dropped");
   chk_sync_release: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (timerSyncModeWr && !timerSyncModeIn && !prescalerResetWr) |=> !preRst_ff)
      else $error("sync release left reset");
   chk_stop_holds: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (tickSourceSelect == tmc_pkg::SRC_STOP && !counterWr) |=> $stable(cnt_ff))
      else $error("stopped counter moved");
   chk_write_wins: assert property (@(posedge sys_clk) disable iff (!rst_b)
      counterWr |=> cnt_ff == $past(counterWrData)) else $error("counter write lost");
   chk_normal_incr: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (tick && !counterWr && mode == tmc_pkg::WGM_NORMAL) |=> cnt_ff == $past(cnt_ff) + CW'(1))
      else $error("normal mode did not count up");
   chk_ctc_clear: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (tick && !counterWr && mode == tmc_pkg::WGM_CTC && cnt_ff == cmpAct_ff) |=> cnt_ff == 8'h00)
      else $error("ctc did not clear at top");
   chk_flag_set: assert property (@(posedge sys_clk) disable iff (!rst_b)
      matchEvt |=> cmpFlag_ff) else $error("match flag not set");
   chk_irq_gate: assert property (@(posedge sys_clk) disable iff (!rst_b)
      compareIrq |-> (cmpFlag_ff && compareIrqEnable && globalIrqEnable))
      else $error("compare irq without cause");
   chk_flag_clear: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (flagClrMatch && !matchEvt) |=> !cmpFlag_ff) else $error("flag clear ignored");
   chk_pwm_buffer: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (compareWr && isPwm(mode) && !bufLoad) |=> $stable(cmpAct_ff))
      else $error("pwm compare not buffered");

endmodule

/* File: tmc_timer_tb.sv */
// tmc_timer_tb: directed bench for the 8-bit timer with compare
// assumes tmc_timer with default width, driven on rising edges
`timescale 1ns/1ps
module tmc_timer_tb;
   // ----------------------------------------------------------------
   // bench signals
   // ----------------------------------------------------------------
   logic       sys_clk;
   logic       rst_b;
   logic [2:0] tickSourceSelect;
   logic [1:0] waveformMode, compareOutputMode;
   logic       timerSyncModeWr, timerSyncModeIn, prescalerResetWr, prescalerResetIn;
   logic       counterWr, compareWr, flagClrMatch, flagClrOvf;
   logic       matchVectorTaken, ovfVectorTaken, externalCountPin;
   logic       compareIrqEnable, overflowIrqEnable, globalIrqEnable;
   logic [7:0] counterWrData, compareWrData, counterValue, compareValue;
   logic       timerSyncMode, sharedPrescalerReset, compareMatchFlag, overflowFlag;
   logic       compareIrq, overflowIrq, compareOutput, atBottom, atMax, timerTick;
   int         failures;
   int         nTests;

   tmc_timer u_dut (
      .sys_clk, .rst_b, .tickSourceSelect, .waveformMode, .compareOutputMode,
      .timerSyncModeWr, .timerSyncModeIn, .prescalerResetWr, .prescalerResetIn,
      .timerSyncMode, .sharedPrescalerReset, .counterWr, .counterWrData, .counterValue,
      .compareWr, .compareWrData, .compareValue, .flagClrMatch, .flagClrOvf,
      .matchVectorTaken, .ovfVectorTaken, .compareIrqEnable, .overflowIrqEnable,
      .globalIrqEnable, .compareMatchFlag, .overflowFlag, .compareIrq, .overflowIrq,
      .externalCountPin, .compareOutput, .atBottom, .atMax, .timerTick
   );

   initial begin
      sys_clk = 1'h0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   // ----------------------------------------------------------------
   // access tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      nTests++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %0t ns: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d, mismatches %0d", nTests, failures);
      if (failures == 0 && nTests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   // one-cycle strobe: 0 presc reset, 1 sync mode, 2..5 flag clears
   task automatic strobe(input int k, input logic d);
      @(posedge sys_clk);
      case (k)
         0: begin prescalerResetWr <= 1'h1; prescalerResetIn <= d; end
         1: begin timerSyncModeWr <= 1'h1; timerSyncModeIn <= d; end
         2: flagClrMatch <= 1'h1;
         3: flagClrOvf <= 1'h1;
         4: matchVectorTaken <= 1'h1;
         default: ovfVectorTaken <= 1'h1;
      endcase
      @(posedge sys_clk);
      {prescalerResetWr, timerSyncModeWr, flagClrMatch} <= 3'h0;
      {flagClrOvf, matchVectorTaken, ovfVectorTaken} <= 3'h0;
      #1;
   endtask

   task automatic wr_cnt(input logic [7:0] d);
      @(posedge sys_clk);
      counterWr     <= 1'h1;
      counterWrData <= d;
      @(posedge sys_clk);
      counterWr <= 1'h0;
      #1;
   endtask

   task automatic wr_cmp(input logic [7:0] d);
      @(posedge sys_clk);
      compareWr     <= 1'h1;
      compareWrData <= d;
      @(posedge sys_clk);
      compareWr <= 1'h0;
      #1;
   endtask

   task automatic set_src(input logic [2:0] s);
      @(posedge sys_clk);
      tickSourceSelect <= s;
      #1;
   endtask

   // guards against a hang anywhere in the sequence
   initial begin
      #2000000;
      failures++;
      print_verdict();
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      failures = 0;
      nTests = 0;
      rst_b = 1'h0;
      {tickSourceSelect, waveformMode, compareOutputMode} = 7'h00;
      {timerSyncModeWr, timerSyncModeIn, prescalerResetWr, prescalerResetIn} = 4'h0;
      {counterWr, compareWr, flagClrMatch, flagClrOvf} = 4'h0;
      {matchVectorTaken, ovfVectorTaken, externalCountPin, compareIrqEnable} = 4'h0;
      {overflowIrqEnable, globalIrqEnable} = 2'h3;
      {counterWrData, compareWrData} = 16'h0000;
      repeat (5) @(posedge sys_clk);
      rst_b <= 1'h1;
      #1;
      check(counterValue, 8'h00);
      check(compareValue, 8'h00);
      check(atBottom, 1'h1);
      check(atMax, 1'h0);
      wr_cnt(8'h3c);
      cyc(4);
      check(counterValue, 8'h3c);
      check(timerTick, 1'h0);
      set_src(3'h1);
      cyc(3);
      check(counterValue, 8'h3f);
      wr_cnt(8'h80);
      check(counterValue, 8'h80);
      cyc(2);
      check(counterValue, 8'h82);
      // overflow at max in normal mode
      wr_cnt(8'hfe);
      cyc(1);
      check(atMax, 1'h1);
      check(overflowFlag, 1'h0);
      cyc(2);
      check(overflowFlag, 1'h1);
      check(overflowIrq, 1'h1);
      strobe(5, 1'h1);
      check(overflowFlag, 1'h0);
      // compare flag one tick after the match, irq gating
      set_src(3'h0);
      wr_cmp(8'h05);
      check(compareValue, 8'h05);
      wr_cnt(8'h03);
      strobe(2, 1'h1);
      check(compareMatchFlag, 1'h0);
      set_src(3'h1);
      cyc(2);
      check(compareMatchFlag, 1'h0);
      cyc(1);
      check(compareMatchFlag, 1'h1);
      check(compareIrq, 1'h0);
      @(posedge sys_clk);
      compareIrqEnable <= 1'h1;
      globalIrqEnable  <= 1'h0;
      #1;
      check(compareIrq, 1'h0);
      @(posedge sys_clk);
      globalIrqEnable <= 1'h1;
      #1;
      check(compareIrq, 1'h1);
      strobe(2, 1'h1);
      check(compareMatchFlag, 1'h0);
      // clear on compare, output set on match
      set_src(3'h0);
      @(posedge sys_clk);
      waveformMode      <= 2'h2;
      compareOutputMode <= 2'h3;
      wr_cmp(8'h03);
      check(compareValue, 8'h03);
      check(compareOutput, 1'h0);
      wr_cnt(8'h00);
      set_src(3'h1);
      cyc(3);
      check(counterValue, 8'h03);
      cyc(1);
      check(counterValue, 8'h00);
      check(compareMatchFlag, 1'h1);
      check(compareOutput, 1'h1);
      // toggle on the next compare match
      @(posedge sys_clk);
      compareOutputMode <= 2'h1;
      cyc(4);
      check(compareOutput, 1'h0);
      set_src(3'h0);
      strobe(4, 1'h1);
      check(compareMatchFlag, 1'h0);
      // fast pwm: write lands in buffer, active stays at 3 until max
      @(posedge sys_clk);
      waveformMode <= 2'h3;
      wr_cmp(8'h80);
      check(compareValue, 8'h80);
      wr_cnt(8'h00);
      set_src(3'h1);
      cyc(5);
      check(compareMatchFlag, 1'h1);
      // phase pwm turns round at max
      set_src(3'h0);
      @(posedge sys_clk);
      waveformMode <= 2'h1;
      wr_cnt(8'hfe);
      set_src(3'h1);
      cyc(2);
      check(counterValue, 8'hfe);
      // prescaler reset, plain and held by sync mode
      set_src(3'h0);
      @(posedge sys_clk);
      waveformMode <= 2'h0;
      strobe(0, 1'h1);
      check(sharedPrescalerReset, 1'h1);
      cyc(1);
      check(sharedPrescalerReset, 1'h0);
      wr_cnt(8'h10);
      strobe(1, 1'h1);
      check(timerSyncMode, 1'h1);
      strobe(0, 1'h1);
      set_src(3'h2);
      cyc(20);
      check(sharedPrescalerReset, 1'h1);
      check(counterValue, 8'h10);
      strobe(1, 1'h0);
      check(sharedPrescalerReset, 1'h0);
      check(timerSyncMode, 1'h0);
      cyc(12);
      check(counterValue, 8'h11);
      // external pin: 7 counts rising, 6 counts falling
      for (int s = 7; s >= 6; s--) begin
         wr_cnt(8'h00);
         set_src(s[2:0]);
         @(posedge sys_clk);
         externalCountPin <= 1'h1;
         cyc(4);
         check(counterValue, (s == 7) ? 8'h01 : 8'h00);
         @(posedge sys_clk);
         externalCountPin <= 1'h0;
         cyc(4);
         check(counterValue, 8'h01);
      end
      // /64 tap phase restarts with the prescaler reset
      strobe(0, 1'h1);
      set_src(3'h3);
      cyc(63);
      check(counterValue, 8'h01);
      cyc(1);
      check(counterValue, 8'h02);
      print_verdict();
   end
endmodule
